/* File: ea_state_pkg.sv */
// Constants and types for the operand address and processing-state unit.
// Assumes a 24-bit address bus, 32-bit general registers and one clock.
//
// Function
// - Register direct selects byte, word or long register
// - Indirect instruction address keeps low 24 bits
// - Displacement added, 16-bit one sign-extended
// - Post-increment: access, then add 1/2/4
// - Pre-decrement: subtract 1/2/4, use and store
// - 8-bit absolute: upper bits forced to ones
// - 16-bit absolute address is sign-extended
// - 32-bit absolute reaches whole address space
// - 24-bit absolute is instruction address, zero-extended
// - Immediates 8/16/32 bits; trap has 2 bits
// - Bit number from 3-bit immediate or register
// - PC-relative: sign-extended displacement, keep 24 bits
// - Memory indirect: zero-extended 8-bit, longword target
// - Odd word/long/branch address rounds down even
// - Modes restricted by instruction class
// - Memory indirect only for jumps and software trap
// - Only 24-bit advanced address mode supported
// - Reset pin low stops all, masks interrupts
// - Watchdog overflow also enters reset state
// - Exceptions pass through vector-fetch state
// - Granted bus request halts processor
// - Sleep or standby enters program stop state
package ea_state_pkg;

    localparam int ADDR_W = 24;
    localparam int REG_W  = 32;

    typedef enum logic [3:0] {
        mode_reg_direct, mode_reg_indirect, mode_disp16, mode_disp32,
        mode_post_inc, mode_pre_dec, mode_abs8, mode_abs16, mode_abs24,
        mode_abs32, mode_imm8, mode_imm16, mode_imm32, mode_pc_rel8,
        mode_pc_rel16, mode_mem_indirect
    } addr_mode_e;

    typedef enum logic [2:0] {
        class_arith, class_transfer, class_bit, class_branch,
        class_jump_instr, class_jump_subroutine_instr,
        class_branch_subroutine_instr, class_software_trap_instr
    } instr_class_e;

    typedef enum logic [1:0] {
        size_byte, size_word, size_long
    } op_size_e;

    typedef enum logic [1:0] {
        sel_byte_high, sel_byte_low, sel_word, sel_long
    } reg_sel_e;

    localparam logic [31:0] step_byte = 32'h0000_0001;
    localparam logic [31:0] step_word = 32'h0000_0002;
    localparam logic [31:0] step_long = 32'h0000_0004;
    localparam logic [7:0]  ones_byte = 8'hff;
    localparam logic [7:0]  zero_byte = 8'h00;
    localparam logic [15:0] ones_half = 16'hffff;
    localparam logic [23:0] zero_hi24 = 24'h00_0000;

endpackage

/* File: ea_state_unit.sv */
// Operand effective-address calculation and CPU processing-state sequencing.
// Assumes register values and instruction fields arrive on clk; pins are async.
`timescale 1ns/1ps

module cpu_address_mode_and_state_unit
    import ea_state_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 chip_init_pin_low,
    input  wire logic                 wdt_overflow,
    input  wire logic                 bus_request,
    input  wire logic                 standby_pin,
    input  wire logic                 ea_start,
    input  wire addr_mode_e           ea_mode,
    input  wire instr_class_e         instr_class,
    input  wire op_size_e             op_size,
    input  wire reg_sel_e             reg_sel,
    input  wire logic [REG_W-1:0]     general_reg_operand,
    input  wire logic [REG_W-1:0]     extended_address_reg,
    input  wire logic [REG_W-1:0]     ext_word,
    input  wire logic [ADDR_W-1:0]    pc_next,
    input  wire logic                 bit_num_from_reg,
    input  wire logic [2:0]           bit_num_imm,
    input  wire logic [1:0]           trap_vector_imm,
    input  wire logic                 exception_req,
    input  wire logic                 vector_done,
    input  wire logic                 sleep_instr,
    input  wire logic                 wake_event,
    output logic [ADDR_W-1:0]         ea_addr,
    output logic                      ea_valid,
    output logic                      ea_is_instr,
    output logic                      ea_mode_illegal,
    output logic [REG_W-1:0]          operand_value,
    output logic                      reg_writeback,
    output logic [REG_W-1:0]          reg_writeback_value,
    output logic                      mem_indirect_fetch,
    output logic [2:0]                bit_number,
    output logic [1:0]                trap_vector,
    output logic                      bus_granted,
    output logic                      irq_masked,
    output logic [2:0]                proc_state
);

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        st_reset, st_exception, st_execute, st_bus_released, st_stop
    } proc_state_e;

    proc_state_e state;
    logic [2:0]  res_sync;
    logic [2:0]  stb_sync;
    logic [1:0]  breq_sync;

    function automatic logic [REG_W-1:0] step_of(input op_size_e s);
        unique case (s)
            size_byte: step_of = step_byte;
            size_word: step_of = step_word;
            default:   step_of = step_long;
        endcase
    endfunction

    function automatic logic mode_ok(input instr_class_e c, input addr_mode_e m);
        unique case (c)
            class_arith:    mode_ok = m inside {mode_reg_direct, mode_imm8, mode_imm16, mode_imm32};
            class_transfer: mode_ok = !(m inside {mode_pc_rel8, mode_pc_rel16, mode_mem_indirect});
            class_bit:      mode_ok = m inside {mode_reg_direct, mode_reg_indirect, mode_abs8,
                                                mode_abs16, mode_abs32};
            class_branch, class_branch_subroutine_instr:
                            mode_ok = m inside {mode_pc_rel8, mode_pc_rel16};
            class_jump_instr, class_jump_subroutine_instr:
                            mode_ok = m inside {mode_reg_indirect, mode_abs24, mode_mem_indirect};
            class_software_trap_instr: mode_ok = 1'b1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Async pins through two flops; first flop read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_sync  <= 3'h0;
            stb_sync  <= 3'h0;
            breq_sync <= 2'h0;
        end else begin
            res_sync  <= {res_sync[1:0], chip_init_pin_low};
            stb_sync  <= {stb_sync[1:0], standby_pin};
            breq_sync <= {breq_sync[0], bus_request};
        end
    end

    wire res_high  = res_sync[1];
    wire res_rise  = res_sync[1] & ~res_sync[2];
    wire standby   = stb_sync[1];
    wire breq      = breq_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Processing state; reset and watchdog win over everything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_reset;
        end else if (!res_high || wdt_overflow) begin
            state <= st_reset;
        end else if (standby) begin
            state <= st_stop;
        end else begin
            unique case (state)
                st_reset:        if (res_rise) state <= st_exception;
                st_exception:    if (vector_done) state <= st_execute;
                st_execute: begin
                    if (breq) state <= st_bus_released;
                    else if (sleep_instr) state <= st_stop;
                    else if (exception_req) state <= st_exception;
                end
                st_bus_released: if (!breq) state <= st_execute;
                st_stop:         if (wake_event) state <= st_exception;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            proc_state  <= 3'h0;
            bus_granted <= 1'b0;
            irq_masked  <= 1'b1;
        end else begin
            proc_state  <= state;
            bus_granted <= (state == st_bus_released);
            irq_masked  <= (state == st_reset);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address arithmetic on 32 bits, only low 24 bits leave
    logic [REG_W-1:0] next_ea;
    logic [REG_W-1:0] next_wb;
    logic [REG_W-1:0] next_opnd;
    logic             next_wb_en;
    logic             next_instr;
    logic             is_mem;
    logic             needs_even;

    always_comb begin
        next_ea    = '0;
        next_wb    = extended_address_reg;
        next_wb_en = 1'b0;
        next_opnd  = '0;
        next_instr = instr_class inside {class_jump_instr, class_jump_subroutine_instr,
                                         class_branch, class_branch_subroutine_instr};
        is_mem     = 1'b1;
        unique case (ea_mode)
            mode_reg_direct: begin
                is_mem = 1'b0;
                unique case (reg_sel)
                    sel_byte_high: next_opnd = {24'h0, general_reg_operand[15:8]};
                    sel_byte_low:  next_opnd = {24'h0, general_reg_operand[7:0]};
                    sel_word:      next_opnd = {16'h0, general_reg_operand[15:0]};
                    sel_long:      next_opnd = general_reg_operand;
                endcase
            end
            mode_reg_indirect: next_ea = extended_address_reg;
            mode_disp16:  next_ea = extended_address_reg + {{16{ext_word[15]}}, ext_word[15:0]};
            mode_disp32:  next_ea = extended_address_reg + ext_word;
            mode_post_inc: begin
                next_ea    = extended_address_reg;
                next_wb    = extended_address_reg + step_of(op_size);
                next_wb_en = 1'b1;
            end
            mode_pre_dec: begin
                next_ea    = extended_address_reg - step_of(op_size);
                next_wb    = next_ea;
                next_wb_en = 1'b1;
            end
            mode_abs8:  next_ea = {ones_byte, ones_half, ext_word[7:0]};
            mode_abs16: next_ea = {{16{ext_word[15]}}, ext_word[15:0]};
            mode_abs24: begin
                next_ea    = {zero_byte, ext_word[23:0]};
                next_instr = 1'b1;
            end
            mode_abs32: next_ea = ext_word;
            mode_imm8:  begin is_mem = 1'b0; next_opnd = {24'h0, ext_word[7:0]}; end
            mode_imm16: begin is_mem = 1'b0; next_opnd = {16'h0, ext_word[15:0]}; end
            mode_imm32: begin is_mem = 1'b0; next_opnd = ext_word; end
            mode_pc_rel8:  next_ea = {zero_byte, pc_next + ext_word[7:0 ] + {{16{ext_word[7]}}, 8'h00}};
            mode_pc_rel16: next_ea = {zero_byte, pc_next + {{8{ext_word[15]}}, ext_word[15:0]}};
            mode_mem_indirect: next_ea = {zero_hi24, ext_word[7:0]};
        endcase
        if (next_instr)
            next_ea = {zero_byte, next_ea[23:0]};
        needs_even = next_instr || (op_size != size_byte) || (ea_mode == mode_mem_indirect);
        if (needs_even)
            next_ea[0] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ea_addr             <= '0;
            ea_valid            <= 1'b0;
            ea_is_instr         <= 1'b0;
            ea_mode_illegal     <= 1'b0;
            operand_value       <= '0;
            reg_writeback       <= 1'b0;
            reg_writeback_value <= '0;
            mem_indirect_fetch  <= 1'b0;
            bit_number          <= 3'h0;
            trap_vector         <= 2'h0;
        end else begin
            // No strobe issues outside program execution; values still load on any ea_start
            ea_valid        <= ea_start && (state == st_execute) && mode_ok(instr_class, ea_mode) && is_mem;
            ea_mode_illegal <= ea_start && (state == st_execute) && !mode_ok(instr_class, ea_mode);
            reg_writeback   <= ea_start && (state == st_execute) && mode_ok(instr_class, ea_mode) && next_wb_en;
            mem_indirect_fetch <= ea_start && (state == st_execute) && (ea_mode == mode_mem_indirect)
                                  && mode_ok(instr_class, ea_mode);
            if (ea_start) begin
                ea_addr             <= next_ea[ADDR_W-1:0];
                ea_is_instr         <= next_instr;
                operand_value       <= next_opnd;
                reg_writeback_value <= next_wb;
                bit_number          <= bit_num_from_reg ? general_reg_operand[2:0] : bit_num_imm;
                trap_vector         <= trap_vector_imm;
            end
        end
    end

endmodule // cpu_address_mode_and_state_unit

/* File: ea_state_checker.sv */
// Checker for the address and state unit.
// Assumes binding to the unit's top module ports.
`timescale 1ns/1ps
module ea_state_checker
    import ea_state_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst_n,
    input wire logic         chip_init_pin_low,
    input wire logic         wdt_overflow,
    input wire logic         ea_start,
    input wire addr_mode_e   ea_mode,
    input wire instr_class_e instr_class,
    input wire op_size_e     op_size,
    input wire logic [31:0]  extended_address_reg,
    input wire logic [31:0]  ext_word,
    input wire logic [23:0]  ea_addr,
    input wire logic         ea_valid,
    input wire logic         ea_mode_illegal,
    input wire logic         reg_writeback,
    input wire logic [31:0]  reg_writeback_value,
    input wire logic         irq_masked,
    input wire logic [2:0]   proc_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Transfer request while executing, legal mode or not
    wire go = ea_start && proc_state == 3'd2 && instr_class == class_transfer;
    wire gb = go && op_size == size_byte;
    ////////////////////////////////////////
    property p_post_inc;
        gb && ea_mode == mode_post_inc |=> reg_writeback && reg_writeback_value == $past(extended_address_reg) + 32'h1;
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("post increment sum wrong");
    property p_pre_dec;
        gb && ea_mode == mode_pre_dec |=> ea_valid && ea_addr == $past(extended_address_reg[23:0]) - 24'h1;
    endproperty
    a_pre_dec: assert property (p_pre_dec) else $error("pre decrement address wrong");
    property p_abs8;
        gb && ea_mode == mode_abs8 |=> ea_addr == {16'hffff, $past(ext_word[7:0])};
    endproperty
    a_abs8: assert property (p_abs8) else $error("short absolute address wrong");
    property p_abs16;
        gb && ea_mode == mode_abs16 |=> ea_addr == {{8{$past(ext_word[15])}}, $past(ext_word[15:0])};
    endproperty
    a_abs16: assert property (p_abs16) else $error("word absolute not sign extended");
    property p_even;
        go && op_size != size_byte && ea_mode == mode_disp32 |=> ea_valid && !ea_addr[0];
    endproperty
    a_even: assert property (p_even) else $error("odd word address not rounded");
    property p_arith;
        ea_start && proc_state == 3'd2 && instr_class == class_arith
            && !(ea_mode inside {mode_reg_direct, mode_imm8, mode_imm16, mode_imm32}) |=> ea_mode_illegal && !ea_valid;
    endproperty
    a_arith: assert property (p_arith) else $error("arith memory mode accepted");
    property p_mem_ind;
        go && ea_mode == mode_mem_indirect |=> ea_mode_illegal && !reg_writeback;
    endproperty
    a_mem_ind: assert property (p_mem_ind) else $error("transfer took memory indirect");
    property p_pin;
        !chip_init_pin_low [*4] |=> proc_state == 3'd0 && irq_masked;
    endproperty
    a_pin: assert property (p_pin) else $error("reset pin low not in reset state");
    property p_wdt;
        wdt_overflow |-> ##[1:2] proc_state == 3'd0;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog did not reset");
    property p_idle;
        ea_start && proc_state != 3'd2 |=> !ea_valid && !reg_writeback;
    endproperty
    a_idle: assert property (p_idle) else $error("address work outside execute");
    c_valid: cover property (ea_valid);
    c_bus: cover property (proc_state == 3'd3);
    c_stop: cover property (proc_state == 3'd4);
endmodule // ea_state_checker

bind cpu_address_mode_and_state_unit ea_state_checker chk (.clk, .rst_n, .chip_init_pin_low, .wdt_overflow,
    .ea_start, .ea_mode, .instr_class, .op_size, .extended_address_reg, .ext_word, .ea_addr, .ea_valid,
    .ea_mode_illegal, .reg_writeback, .reg_writeback_value, .irq_masked, .proc_state);

/* File: bus_master_model.sv */
// Second bus master asking the unit for the bus.
// Assumes the bench raises want and the unit answers with bus_granted.
`timescale 1ns/1ps
module bus_master_model (
    input  wire logic clk,
    input  wire logic want,
    input  wire logic bus_granted,
    output logic      bus_request
);
    initial bus_request = 1'b0;
    // Held until granted, so a short want cannot vanish unseen
    always @(posedge clk) begin
        bus_request <= want || (bus_request && !bus_granted);
    end
endmodule // bus_master_model

/* File: cpu_address_mode_and_state_unit_tb.sv */
// Self-checking bench for the address and state unit.
// Assumes package, unit, checker and bus master model compiled first.
`timescale 1ns/1ps
module cpu_address_mode_and_state_unit_tb;
    import ea_state_pkg::*;
    logic clk = 0, rst_n = 0, chip_init_pin_low = 0, standby_pin = 0, want = 0, bus_request;
    logic ea_start = 0, bit_num_from_reg = 0, exception_req = 0;
    logic [3:0] ctl = 0;
    addr_mode_e ea_mode = mode_reg_direct;
    instr_class_e instr_class = class_transfer;
    op_size_e op_size = size_byte;
    reg_sel_e reg_sel = sel_long;
    logic [31:0] general_reg_operand = 0, extended_address_reg = 0, ext_word = 0, operand_value, reg_writeback_value;
    logic [23:0] pc_next = 24'h001000, ea_addr;
    logic [2:0] bit_num_imm = 3'h5, bit_number, proc_state;
    logic [1:0] trap_vector_imm = 2'h2, trap_vector;
    logic ea_valid, ea_is_instr, ea_mode_illegal, reg_writeback, mem_indirect_fetch, bus_granted, irq_masked;
    int num_errors = 0, compares = 0;
    always #10 clk = ~clk;
    cpu_address_mode_and_state_unit DUT (.clk, .rst_n, .chip_init_pin_low, .wdt_overflow(ctl[0]), .bus_request,
        .standby_pin, .ea_start, .ea_mode, .instr_class, .op_size, .reg_sel, .general_reg_operand,
        .extended_address_reg, .ext_word, .pc_next, .bit_num_from_reg, .bit_num_imm, .trap_vector_imm,
        .exception_req, .vector_done(ctl[1]), .sleep_instr(ctl[2]), .wake_event(ctl[3]), .ea_addr, .ea_valid,
        .ea_is_instr, .ea_mode_illegal, .operand_value, .reg_writeback, .reg_writeback_value,
        .mem_indirect_fetch, .bit_number, .trap_vector, .bus_granted, .irq_masked, .proc_state);
    bus_master_model far (.clk, .want, .bus_granted, .bus_request);
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic state(input logic [2:0] s);
        for (int i = 0; i < 40 && proc_state !== s; i++) begin
            @(posedge clk);
            #1;
        end
        chk(proc_state, s);
    endtask
    // Pulse of one cycle: 0 watchdog, 1 vector done, 2 sleep, 3 wake
    task automatic pulse(input int k);
        @(posedge clk);
        ctl[k] <= 1'b1;
        @(posedge clk);
        ctl[k] <= 1'b0;
    endtask
    // Valid check: 0 none expected, 1 expected, 2 not judged
    task automatic ea(addr_mode_e m, instr_class_e c, op_size_e s, logic [31:0] ar, ex, logic [23:0] ad, int v);
        @(posedge clk);
        ea_start <= 1'b1;
        ea_mode <= m;
        instr_class <= c;
        op_size <= s;
        extended_address_reg <= ar;
        ext_word <= ex;
        @(posedge clk);
        ea_start <= 1'b0;
        #1;
        if (v < 2) chk(ea_valid, v[0]);
        if (v > 0) chk(ea_addr, ad);
    endtask
    task automatic run_vector;
        pulse(1);
        state(3'd2);
    endtask
    ////////////////////////////////////////
    task automatic t_modes;
        for (int k = 0; k < 3; k++) begin
            ea(mode_post_inc, class_transfer, op_size_e'(k), 32'h100, 0, 24'h100, 1);
            chk(reg_writeback_value, 32'h100 + (32'h1 << k));
        end
        ea(mode_pre_dec, class_transfer, size_long, 32'h200, 0, 24'h1fc, 1);
        chk(reg_writeback_value, 32'h1fc);
        ea(mode_disp16, class_transfer, size_byte, 32'h1000, 32'hfff0, 24'h000ff0, 1);
        ea(mode_disp32, class_transfer, size_word, 32'h100000, 32'h11, 24'h100010, 1);
        ea(mode_abs8, class_transfer, size_byte, 0, 32'h12, 24'hffff12, 1);
        ea(mode_abs16, class_transfer, size_byte, 0, 32'h8004, 24'hff8004, 1);
        ea(mode_abs16, class_transfer, size_byte, 0, 32'h7fff, 24'h007fff, 1);
        ea(mode_abs32, class_transfer, size_byte, 0, 32'habcdef, 24'habcdef, 1);
        ea(mode_abs24, class_jump_instr, size_long, 0, 32'hab123456, 24'h123456, 2);
        ea(mode_reg_indirect, class_jump_instr, size_long, 32'h55123459, 0, 24'h123458, 2);
        ea(mode_pc_rel8, class_branch, size_word, 0, 32'hfe, 24'h000ffe, 2);
        ea(mode_pc_rel16, class_branch_subroutine_instr, size_word, 0, 32'h8000, 24'hff9000, 2);
        ea(mode_mem_indirect, class_jump_subroutine_instr, size_long, 0, 32'h41, 24'h000040, 2);
        chk(mem_indirect_fetch, 1);
    endtask
    task automatic t_refuse;
        ea(mode_abs16, class_arith, size_byte, 0, 0, 0, 0);
        chk(ea_mode_illegal, 1);
        ea(mode_mem_indirect, class_transfer, size_long, 0, 0, 0, 0);
        chk(ea_mode_illegal, 1);
        ea(mode_pc_rel8, class_transfer, size_byte, 0, 0, 0, 0);
        chk(ea_mode_illegal, 1);
    endtask
    task automatic t_operands;
        general_reg_operand <= 32'h1234abcb;
        ea(mode_reg_direct, class_arith, size_long, 0, 0, 0, 0);
        chk(operand_value, 32'h1234abcb);
        ea(mode_reg_direct, class_bit, size_byte, 0, 0, 0, 0);
        chk(bit_number, 3'h5);
        ea(mode_imm8, class_software_trap_instr, size_byte, 0, 32'h7, 0, 2);
        chk(trap_vector, 2'h2);
    endtask
    task automatic t_states;
        want <= 1'b1;
        state(3'd3);
        chk(bus_granted, 1);
        ea(mode_abs32, class_transfer, size_byte, 0, 0, 0, 0);
        want <= 1'b0;
        state(3'd2);
        pulse(2);
        state(3'd4);
        ea(mode_abs32, class_transfer, size_byte, 0, 0, 0, 0);
        pulse(3);
        state(3'd1);
        run_vector();
        standby_pin <= 1'b1;
        state(3'd4);
        standby_pin <= 1'b0;
        repeat (3) @(posedge clk);
        pulse(3);
        state(3'd1);
        run_vector();
        exception_req <= 1'b1;
        state(3'd1);
        exception_req <= 1'b0;
        run_vector();
        pulse(0);
        state(3'd0);
        chk(irq_masked, 1);
        chip_init_pin_low <= 1'b0;
        repeat (5) @(posedge clk);
        chk(proc_state, 3'd0);
        chip_init_pin_low <= 1'b1;
        state(3'd1);
        run_vector();
    endtask
    ////////////////////////////////////////
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        // Whole run needs well under a thousand cycles
        #200us;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(irq_masked, 1);
        chip_init_pin_low <= 1'b1;
        state(3'd1);
        chk(irq_masked, 0);
        run_vector();
        t_modes();
        t_refuse();
        t_operands();
        t_states();
        complete_run();
    end
endmodule // cpu_address_mode_and_state_unit_tb
